// file: verilog/asfr_pkg.sv
// Package of constants and types for the analog select and fault reset block
package asfr_pkg;
   // Pair select codes
   localparam logic [1:0] PAIR_CURRENT = 2'h0;
   localparam logic [1:0] PAIR_AUX = 2'h1;
   // Range codes
   localparam logic [1:0] RANGE_UNIPOLAR = 2'h0;
   localparam logic [1:0] RANGE_BIPOLAR = 2'h1;
   localparam logic [1:0] RANGE_BIPOLAR_AUX = 2'h2;
   // Frequency source code that routes the analog terminals
   localparam logic [1:0] FSRC_ANALOG = 2'h1;
   // Reference source encoding
   localparam logic [1:0] SRC_PRIMARY = 2'h0;
   localparam logic [1:0] SRC_CURRENT = 2'h1;
   localparam logic [1:0] SRC_AUX = 2'h2;
   // Clock and timebase
   localparam int CLK_HZ = 200000000;
   localparam int TICK_HZ = 1000;
   localparam int TICK_DIV = CLK_HZ / TICK_HZ;
   // Times in milliseconds, counted in timebase ticks
   localparam int RS_MIN_MS = 12;
   localparam int ALARM_CLR_MS = 30;
   localparam int STUCK_MS = 4000;
   localparam int RS_MIN_TICKS = RS_MIN_MS * TICK_HZ / 1000;
   localparam int ALARM_CLR_TICKS = ALARM_CLR_MS * TICK_HZ / 1000;
   localparam int STUCK_TICKS = STUCK_MS * TICK_HZ / 1000;
   // APB register byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
   // Control register fields
   localparam int CTRL_PAIR_LSB = 0;
   localparam int CTRL_RANGE_LSB = 2;
   localparam int CTRL_FSRC_LSB = 4;
   localparam int CTRL_EDGE_BIT = 6;
   localparam int CTRL_NC_BIT = 7;
   // Reset values
   localparam logic [31:0] CTRL_RESET = 32'h0000_0011;
   localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
   // Interrupt bits
   localparam int IRQ_RESET_DONE = 0;
   localparam int IRQ_SHORT_PULSE = 1;
   localparam int IRQ_STUCK = 2;
   localparam int IRQ_NC_REJECT = 3;
   // Reset sequencer states, one-hot
   typedef enum logic [2:0] {
      ASFR_IDLE = 3'h1,
      ASFR_HELD = 3'h2,
      ASFR_CLEAR = 3'h4
   } asfr_seq_t;
endpackage

// file: verilog/asfr_sync_if.sv
// Interface carrying synchronised terminal levels between modules
`timescale 1ns/1ps
interface asfr_sync_if;
   logic at_level; // Current/voltage select, synchronised
   logic rs_level; // Fault clear input, synchronised
   logic fw_level; // Forward run, synchronised
   logic rv_level; // Reverse run, synchronised
   modport src (output at_level, rs_level, fw_level, rv_level);
   modport dst (input at_level, rs_level, fw_level, rv_level);
endinterface

// file: verilog/asfr_sync.sv
// Two-flop synchronisers for the terminal inputs
`timescale 1ns/1ps
module asfr_sync #(
   parameter int WIDTH = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] raw,
   asfr_sync_if.src sync
);
   // First and second stages; stage one feeds only stage two
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } asfr_sync_st_t;
   asfr_sync_st_t st;
   asfr_sync_st_t next_st;

   // Shift every terminal through both stages
   always_comb begin
      next_st = st;
      next_st.s1 = raw; // R17
      next_st.s2 = st.s1; // R17
   end

   // Register stage, cleared to idle levels
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign sync.at_level = st.s2[0];
   assign sync.rs_level = st.s2[1];
   assign sync.fw_level = st.s2[2];
   assign sync.rv_level = st.s2[3];
endmodule // asfr_sync

// file: verilog/asfr_top.sv
// Analog reference select and fault reset logic with APB registers
// Overview of operation
// (R01) Select on, pair 00: current loop input
// (R02) Select on, pair 01: auxiliary voltage input
// (R03) Select off: primary voltage input always
// (R04) Range setting decides bipolar treatment
// (R05) Current loop never bipolar; direction from run
// (R06) Other party sets frequency source to analog
// (R07) Reset cancels trip state
// (R08) Reset acts on full on-off pulse
// (R09) Other party holds reset pulse 12 ms
// (R10) Alarm deasserts within 30 ms of reset
// (R11) Input held: output off, trip cleared
// (R12) Active run restarts motor after reset
// (R13) Input stuck over 4 s: comm error
// (R14) Edge setting picks leading or trailing action
// (R15) Fault clear input accepts normally-open only
// (R16) Power-up performs the same reset
// (R17) Terminals synchronised before edge detection
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
module asfr_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic current_voltage_select_input,
   input wire logic fault_clear_input,
   input wire logic forward_run_command,
   input wire logic reverse_run_command,
   input wire logic trip_event,
   input wire logic operator_key,
   output logic [1:0] ref_source,
   output logic ref_bipolar,
   output logic ref_from_analog,
   output logic run_forward,
   output logic run_reverse,
   output logic motor_enable,
   output logic alarm,
   output logic reset_pulse,
   output logic comm_error,
   output logic irq
);
   // Synchronised terminal levels
   asfr_sync_if sif ();

   // Terminal synchronisers
   asfr_sync #(
      .WIDTH(4)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .raw({reverse_run_command, forward_run_command,
            fault_clear_input, current_voltage_select_input}),
      .sync(sif)
   );

   // Whole state of the block
   typedef struct packed {
      logic [31:0] ctrl; // Pair, range, source, edge, polarity
      logic [3:0] irq_stat; // Sticky events
      logic [3:0] irq_mask; // Interrupt enables
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      asfr_pkg::asfr_seq_t seq; // Reset sequencer
      logic rs_prev; // Previous synchronised reset level
      logic [17:0] div_cnt; // Timebase divider
      logic [11:0] hold_ms; // Width of current reset pulse
      logic [11:0] clr_ms; // Time since reset onset
      logic powerup; // Power-up reset still pending
      logic trip; // Trip state
      logic [1:0] ref_source;
      logic ref_bipolar;
      logic ref_from_analog;
      logic run_forward;
      logic run_reverse;
      logic motor_enable;
      logic alarm;
      logic reset_pulse;
      logic comm_error;
      logic irq;
   } asfr_st_t;
   asfr_st_t st;
   asfr_st_t next_st;

   // Decoded control fields
   logic [1:0] pair_sel;
   logic [1:0] range_sel;
   logic [1:0] fsrc_sel;
   logic edge_trailing;
   assign pair_sel = st.ctrl[asfr_pkg::CTRL_PAIR_LSB +: 2];
   assign range_sel = st.ctrl[asfr_pkg::CTRL_RANGE_LSB +: 2];
   assign fsrc_sel = st.ctrl[asfr_pkg::CTRL_FSRC_LSB +: 2];
   assign edge_trailing = st.ctrl[asfr_pkg::CTRL_EDGE_BIT];

   // Next-state logic for sequencer, references and bus
   always_comb begin
      logic tick;
      logic rise;
      logic fall;
      logic fire;
      logic [3:0] ev;
      logic wr;
      logic rd;
      tick = 1'b0;
      rise = 1'b0;
      fall = 1'b0;
      fire = 1'b0;
      ev = 4'h0;
      wr = 1'b0;
      rd = 1'b0;
      next_st = st;
      next_st.reset_pulse = 1'b0;
      next_st.pready = 1'b0;
      next_st.pslverr = 1'b0;

      // Millisecond timebase enable
      if (st.div_cnt == 18'(asfr_pkg::TICK_DIV - 1)) begin
         next_st.div_cnt = 18'h0;
         tick = 1'b1;
      end else begin
         next_st.div_cnt = st.div_cnt + 18'h1;
      end

      // Edges of the clean reset level only
      rise = sif.rs_level && !st.rs_prev; // R17
      fall = !sif.rs_level && st.rs_prev; // R17
      next_st.rs_prev = sif.rs_level;

      // Reference selection
      if (!sif.at_level) begin
         next_st.ref_source = asfr_pkg::SRC_PRIMARY; // R03
      end else if (pair_sel == asfr_pkg::PAIR_CURRENT) begin
         next_st.ref_source = asfr_pkg::SRC_CURRENT; // R01
      end else if (pair_sel == asfr_pkg::PAIR_AUX) begin
         next_st.ref_source = asfr_pkg::SRC_AUX; // R02
      end else begin
         next_st.ref_source = asfr_pkg::SRC_PRIMARY; // Undefined pair code
      end
      // Bipolar only for voltage sources; the loop input is 4-20 mA
      next_st.ref_bipolar = (range_sel != asfr_pkg::RANGE_UNIPOLAR)
         && (next_st.ref_source != asfr_pkg::SRC_CURRENT); // R04 R05
      // Analog flag set only with analog frequency source; ref_source follows the select regardless
      next_st.ref_from_analog = (fsrc_sel == asfr_pkg::FSRC_ANALOG); // R06

      // Trip capture
      if (trip_event) begin
         next_st.trip = 1'b1;
      end

      // Reset sequencer
      case (st.seq)
         asfr_pkg::ASFR_IDLE: begin
            if (st.powerup) begin
               fire = 1'b1; // R16
               next_st.powerup = 1'b0;
            end else if (rise) begin
               next_st.seq = asfr_pkg::ASFR_HELD;
               next_st.hold_ms = 12'h0;
               next_st.clr_ms = 12'h0;
               if (!edge_trailing) begin
                  fire = 1'b1; // R14
               end
            end
         end
         asfr_pkg::ASFR_HELD: begin
            // Output off and trip cleared while held
            next_st.motor_enable = 1'b0; // R11
            next_st.trip = 1'b0; // R11
            if (tick && st.hold_ms != 12'hFFF) begin
               next_st.hold_ms = st.hold_ms + 12'h1;
            end
            if (tick && st.clr_ms != 12'hFFF) begin
               next_st.clr_ms = st.clr_ms + 12'h1;
            end
            if (st.hold_ms == 12'(asfr_pkg::STUCK_TICKS)) begin
               next_st.comm_error = 1'b1; // R13
               ev[asfr_pkg::IRQ_STUCK] = tick;
            end
            if (fall) begin
               // Full on-off pulse completes the operation
               next_st.seq = asfr_pkg::ASFR_CLEAR; // R08
               if (st.hold_ms < 12'(asfr_pkg::RS_MIN_TICKS)) begin
                  ev[asfr_pkg::IRQ_SHORT_PULSE] = 1'b1; // R09
               end
               if (edge_trailing) begin
                  fire = 1'b1; // R14
               end
            end
         end
         asfr_pkg::ASFR_CLEAR: begin
            // Released: resume normal power-on operation
            next_st.seq = asfr_pkg::ASFR_IDLE; // R11
            if (rise) begin
               next_st.seq = asfr_pkg::ASFR_HELD;
               next_st.hold_ms = 12'h0;
               next_st.clr_ms = 12'h0;
               // A new press right after release still acts on its edge
               if (!edge_trailing) begin
                  fire = 1'b1; // R14
               end
            end
         end
         default: begin
            next_st.seq = asfr_pkg::ASFR_IDLE;
         end
      endcase

      // Reset operation: cancel trip and alarm at once, well inside 30 ms
      if (fire) begin
         next_st.trip = 1'b0; // R07
         next_st.alarm = 1'b0; // R10
         next_st.reset_pulse = 1'b1;
         ev[asfr_pkg::IRQ_RESET_DONE] = 1'b1;
      end
      // Alarm follows trip, but is forced low at the clear deadline
      if (trip_event) begin
         next_st.alarm = 1'b1;
      end else if (st.seq == asfr_pkg::ASFR_HELD &&
                   st.clr_ms >= 12'(asfr_pkg::ALARM_CLR_TICKS)) begin
         next_st.alarm = 1'b0; // R10
      end

      // Motor runs whenever no trip, not held, and exactly one run command is on
      if (next_st.seq != asfr_pkg::ASFR_HELD && !next_st.trip) begin
         next_st.motor_enable = sif.fw_level ^ sif.rv_level; // R12
      end else begin
         next_st.motor_enable = 1'b0;
      end
      // Direction comes from run commands only
      next_st.run_forward = sif.fw_level && !sif.rv_level; // R05
      next_st.run_reverse = sif.rv_level && !sif.fw_level; // R05

      // Operator key clears comm error once input released
      if (st.comm_error && !sif.rs_level && operator_key) begin
         next_st.comm_error = 1'b0; // R13
      end

      // APB access phase, answered in one cycle
      wr = psel && penable && pwrite && !st.pready;
      rd = psel && penable && !pwrite && !st.pready;
      if (psel && penable && !st.pready) begin
         next_st.pready = 1'b1;
      end
      if (wr) begin
         case (paddr)
            asfr_pkg::ADDR_CTRL: begin
               next_st.ctrl = {24'h0, pwdata[7:0]};
               if (pwdata[asfr_pkg::CTRL_NC_BIT]) begin
                  // Normally-closed refused for this terminal
                  next_st.ctrl[asfr_pkg::CTRL_NC_BIT] = 1'b0; // R15
                  ev[asfr_pkg::IRQ_NC_REJECT] = 1'b1; // R15
               end
            end
            asfr_pkg::ADDR_IRQ_STAT: begin
               next_st.irq_stat = st.irq_stat & ~pwdata[3:0];
            end
            asfr_pkg::ADDR_IRQ_MASK: begin
               next_st.irq_mask = pwdata[3:0];
            end
            asfr_pkg::ADDR_STATUS: begin
               next_st.irq_stat = st.irq_stat;
            end
            default: begin
               next_st.pslverr = 1'b1;
            end
         endcase
      end
      if (rd) begin
         case (paddr)
            asfr_pkg::ADDR_CTRL: next_st.prdata = st.ctrl;
            asfr_pkg::ADDR_STATUS: next_st.prdata = {22'h0,
               st.seq == asfr_pkg::ASFR_HELD, sif.rs_level, st.comm_error,
               st.alarm, st.trip, st.motor_enable, st.ref_bipolar,
               st.ref_from_analog, st.ref_source};
            asfr_pkg::ADDR_IRQ_STAT: next_st.prdata = {28'h0, st.irq_stat};
            asfr_pkg::ADDR_IRQ_MASK: next_st.prdata = {28'h0, st.irq_mask};
            default: begin
               next_st.prdata = 32'h0;
               next_st.pslverr = 1'b1;
            end
         endcase
      end
      // Set wins over a clear in the same cycle
      next_st.irq_stat = next_st.irq_stat | ev;
      next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
   end

   // State register; power-up reset pending after release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
         st.ctrl <= asfr_pkg::CTRL_RESET;
         st.irq_mask <= asfr_pkg::IRQ_MASK_RESET;
         st.seq <= asfr_pkg::ASFR_IDLE;
         st.powerup <= 1'b1; // R16
      end else begin
         st <= next_st;
      end
   end

   assign prdata = st.prdata;
   assign pready = st.pready;
   assign pslverr = st.pslverr;
   assign ref_source = st.ref_source;
   assign ref_bipolar = st.ref_bipolar;
   assign ref_from_analog = st.ref_from_analog;
   assign run_forward = st.run_forward;
   assign run_reverse = st.run_reverse;
   assign motor_enable = st.motor_enable;
   assign alarm = st.alarm;
   assign reset_pulse = st.reset_pulse;
   assign comm_error = st.comm_error;
   assign irq = st.irq;
endmodule // asfr_top

// file: verification/asfr_monitor.sv
// Checker of the select and fault clear block outputs
`timescale 1ns/1ps
module asfr_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic current_voltage_select_input,
   input wire logic fault_clear_input,
   input wire logic [1:0] ref_source,
   input wire logic ref_bipolar,
   input wire logic run_forward,
   input wire logic run_reverse,
   input wire logic motor_enable,
   input wire logic alarm,
   input wire logic reset_pulse
);
   logic [2:0] since; // Edges since reset release, saturating
   logic [5:0] hist; // Recent raw fault clear levels
   logic near_edge; // A raw edge lies inside the history
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // History lets a pulse be traced to its input edge or to power-up
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         since <= 3'h0;
         hist <= 6'h00;
      end else begin
         since <= (since == 3'h7) ? since : since + 3'h1;
         hist <= {hist[4:0], fault_clear_input};
      end
   end
   assign near_edge = (hist != 6'h00) && (hist != 6'h3F);
   a_sel_off_primary: assert property (
      (!current_voltage_select_input)[*5]
      |=> ref_source == asfr_pkg::SRC_PRIMARY)
      else $error("primary input not chosen");
   a_current_not_bipolar: assert property (
      ref_source == asfr_pkg::SRC_CURRENT |-> !ref_bipolar)
      else $error("current loop treated as bipolar");
   a_held_motor_off: assert property (
      fault_clear_input[*5] |=> !motor_enable)
      else $error("motor on while reset held");
   a_pulse_has_cause: assert property (
      reset_pulse |-> near_edge || since < 3'h3)
      else $error("reset pulse without cause");
   a_pulse_single_cycle: assert property (
      reset_pulse |=> !reset_pulse)
      else $error("reset pulse too long");
   a_alarm_cleared: assert property (
      reset_pulse |-> ##[0:1] !alarm)
      else $error("alarm kept after reset");
   a_motor_one_dir: assert property (
      motor_enable |-> run_forward != run_reverse)
      else $error("motor on without single run command");
   a_nc_reads_zero: assert property (
      psel && penable && pready && !pwrite
      && paddr == asfr_pkg::ADDR_CTRL |-> !prdata[7])
      else $error("normally closed bit read as one");
   // Main scenarios: leading and trailing pulses, aux bipolar
   cover property (reset_pulse && fault_clear_input);
   cover property (reset_pulse && !fault_clear_input && since == 3'h7);
   cover property (ref_source == asfr_pkg::SRC_AUX && ref_bipolar);
endmodule // asfr_monitor
bind asfr_top asfr_monitor u_mon (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .prdata, .pready, .current_voltage_select_input,
   .fault_clear_input, .ref_source, .ref_bipolar, .run_forward,
   .run_reverse, .motor_enable, .alarm, .reset_pulse);

// file: verification/asfr_contacts.sv
// Model of the external contacts that drive the terminals
`timescale 1ns/1ps
module asfr_contacts (
   input wire logic pclk,
   output logic current_voltage_select_input,
   output logic fault_clear_input,
   output logic forward_run_command,
   output logic reverse_run_command
);
   // Contacts open at power-up
   initial begin
      current_voltage_select_input = 1'b0;
      fault_clear_input = 1'b0;
      forward_run_command = 1'b0;
      reverse_run_command = 1'b0;
   end
   // Levels change just after an edge, like a relay driver
   task automatic set_run(input logic fw, input logic rv);
      @(posedge pclk);
      forward_run_command <= fw;
      reverse_run_command <= rv;
   endtask
   task automatic set_at(input logic v);
      @(posedge pclk);
      current_voltage_select_input <= v;
   endtask
   // A real hold of 12 ms is 2.4 million cycles, too long for this run,
   // so holds are short on purpose and raise the short-pulse flag
   task automatic hold_rs(input int cycles);
      @(posedge pclk);
      fault_clear_input <= 1'b1;
      repeat (cycles) @(posedge pclk);
      fault_clear_input <= 1'b0;
   endtask
endmodule // asfr_contacts

// file: verification/tb_analog_select_and_fault_reset.sv
// Testbench of the analog select and fault reset block
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
   $display("[ERR] %0t got %h want %h", $time, g, e); end end
module tb_analog_select_and_fault_reset;
   logic pclk, presetn, psel, penable, pwrite, trip_event, operator_key;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, err, ref_bipolar, ref_from_analog, irq;
   logic run_forward, run_reverse, motor_enable, alarm, comm_error;
   logic reset_pulse;
   logic [1:0] ref_source;
   wire current_voltage_select_input, fault_clear_input;
   wire forward_run_command, reverse_run_command;
   int fails = 0;
   int comparisons = 0;
   int cycles = 0;
   int n_hi = 0; // Pulses seen while the input was held
   int n_lo = 0; // Pulses seen while the input was released
   asfr_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .current_voltage_select_input,
      .fault_clear_input, .forward_run_command, .reverse_run_command,
      .trip_event, .operator_key, .ref_source, .ref_bipolar,
      .ref_from_analog, .run_forward, .run_reverse, .motor_enable, .alarm,
      .reset_pulse, .comm_error, .irq);
   asfr_contacts cont (.pclk, .current_voltage_select_input,
      .fault_clear_input, .forward_run_command, .reverse_run_command);
   // 200 MHz clock
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   // Classify each reset pulse by the input level at that moment
   always @(posedge pclk) begin
      if (reset_pulse === 1'b1 && fault_clear_input === 1'b1) n_hi++;
      if (reset_pulse === 1'b1 && fault_clear_input !== 1'b1) n_lo++;
   end
   // Hang guard, far above the few hundred cycles the run needs
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 8000) begin
         fails++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish;
      if (fails == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // One APB transfer; waits for pready, the hang guard catches a stuck slave
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Request stands until pready is seen high at a rising edge
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Power-up pulse, reset values, unmapped address, W1C clear
   task automatic t_power_up;
      repeat (4) @(posedge pclk);
      `CHK(n_lo, 1)
      apb(1'b0, asfr_pkg::ADDR_CTRL, 32'h0);
      `CHK(rd, asfr_pkg::CTRL_RESET)
      apb(1'b0, asfr_pkg::ADDR_IRQ_MASK, 32'h0);
      `CHK(rd[3:0], asfr_pkg::IRQ_MASK_RESET)
      apb(1'b0, asfr_pkg::ADDR_IRQ_STAT, 32'h0);
      `CHK(rd[0], 1'b1)
      apb(1'b0, 8'h10, 32'h0);
      `CHK(err, 1'b1)
      apb(1'b1, asfr_pkg::ADDR_IRQ_STAT, 32'h0000_000F);
      apb(1'b0, asfr_pkg::ADDR_IRQ_STAT, 32'h0);
      `CHK(rd[3:0], 4'h0)
   endtask
   // Every select level, pair code and range code
   task automatic t_select;
      logic [1:0] src;
      logic bip;
      for (int a = 0; a < 2; a++) begin
         cont.set_at(a[0]);
         for (int p = 0; p < 4; p++) begin
            for (int r = 0; r < 3; r++) begin
               apb(1'b1, asfr_pkg::ADDR_CTRL, {28'h0, r[1:0], p[1:0]} |
                  32'h10);
               repeat (4) @(posedge pclk);
               src = (a == 0) ? asfr_pkg::SRC_PRIMARY :
                  (p == 0) ? asfr_pkg::SRC_CURRENT :
                  (p == 1) ? asfr_pkg::SRC_AUX : asfr_pkg::SRC_PRIMARY;
               bip = (r != 0) && (src != asfr_pkg::SRC_CURRENT);
               `CHK(ref_source, src)
               `CHK(ref_bipolar, bip)
               `CHK(ref_from_analog, 1'b1)
            end
         end
      end
      apb(1'b1, asfr_pkg::ADDR_CTRL, 32'h0);
      repeat (2) @(posedge pclk);
      `CHK(ref_from_analog, 1'b0)
   endtask
   // Trip, then a leading-edge reset with the run command left on
   task automatic t_trip;
      int h;
      apb(1'b1, asfr_pkg::ADDR_CTRL, 32'h10);
      cont.set_run(1'b1, 1'b0);
      trip_event <= 1'b1;
      @(posedge pclk);
      trip_event <= 1'b0;
      repeat (4) @(posedge pclk);
      `CHK(alarm, 1'b1)
      `CHK(motor_enable, 1'b0)
      h = n_hi;
      fork
         cont.hold_rs(10);
         begin
            repeat (8) @(posedge pclk);
            `CHK(motor_enable, 1'b0)
            `CHK(n_hi, h + 1)
            `CHK(alarm, 1'b0)
         end
      join
      repeat (6) @(posedge pclk);
      `CHK(motor_enable, 1'b1)
      `CHK(run_forward, 1'b1)
      `CHK(run_reverse, 1'b0)
      `CHK(comm_error, 1'b0)
      // Swap to reverse: direction follows the run commands only
      cont.set_run(1'b0, 1'b1);
      repeat (4) @(posedge pclk);
      `CHK(run_reverse, 1'b1)
      `CHK(run_forward, 1'b0)
      `CHK(motor_enable, 1'b1)
      apb(1'b0, asfr_pkg::ADDR_STATUS, 32'h0);
      `CHK(rd[5:4], 2'h1)
      `CHK(rd[9:8], 2'h0)
      apb(1'b0, asfr_pkg::ADDR_IRQ_STAT, 32'h0);
      `CHK(rd[1], 1'b1)
   endtask
   // Trailing edge: nothing while held, one pulse after release
   task automatic t_trailing;
      int h;
      int hh;
      apb(1'b1, asfr_pkg::ADDR_CTRL, 32'h50);
      h = n_lo;
      hh = n_hi;
      cont.hold_rs(8);
      `CHK(n_hi, hh)
      repeat (6) @(posedge pclk);
      `CHK(n_lo, h + 1)
   endtask
   // Normally-closed refusal raises a maskable interrupt
   task automatic t_irq;
      apb(1'b1, asfr_pkg::ADDR_IRQ_STAT, 32'h0000_000F);
      apb(1'b1, asfr_pkg::ADDR_CTRL, 32'h90);
      apb(1'b0, asfr_pkg::ADDR_CTRL, 32'h0);
      `CHK(rd[7], 1'b0)
      apb(1'b0, asfr_pkg::ADDR_IRQ_STAT, 32'h0);
      `CHK(rd[3], 1'b1)
      `CHK(irq, 1'b0)
      apb(1'b1, asfr_pkg::ADDR_IRQ_MASK, 32'h8);
      repeat (2) @(posedge pclk);
      `CHK(irq, 1'b1)
      apb(1'b1, asfr_pkg::ADDR_IRQ_STAT, 32'h8);
      repeat (2) @(posedge pclk);
      `CHK(irq, 1'b0)
   endtask
   // Main sequence
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      trip_event = 1'b0;
      operator_key = 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_power_up();
      t_select();
      t_trip();
      t_trailing();
      t_irq();
      tally_and_finish();
   end
endmodule // tb_analog_select_and_fault_reset
